// ==== design/cas_cfg.svh ====
/*
 constants of the arithmetic and processor status register bank:
 data-memory addresses, field positions, reset values.
 assumes it is included by bare name from the design files only.
*/
// Overview of operation
// - flag-updating ops targeting register ignore writes to the flags they affect
// - subtraction carry and digit carry mean no-borrow
// - signed range flag on result beyond +127/-128
// - operands from working register, file or literal
// - arith status at 04h, modes reset ones
// - pointer one step: 00 dec, 01 inc, 1x hold
// - pointer zero step uses the same encoding
// - zero flag set when add/sub/logic/clear result is zero
// - addition digit carry from fourth low bit
// - subtract by adding complement, carry from msb
// - rotate through carry loads carry from source
// - processor status at 06h, top two read zero
// - stack, expiry, sleep flags ignore software writes
// - stack flag clears at Fh, locks after wrap
// - global mask set blocks all interrupts
// - expiry flag set by powerup/clear/sleep, cleared timeout
// - sleep flag set powerup/clear, cleared by sleep
// - power-up flag zero after power-on, software sets
// - supply dip flag zero after brownout when enabled
// - external pin reset keeps expiry and sleep flags
// - every reset: stack pointer zero, stack flag one
// - pointer stepping never touches arithmetic flags
`ifndef CAS_CFG_SVH
`define CAS_CFG_SVH

`define CAS_ADDR_ARITH     8'h04
`define CAS_ADDR_PROC      8'h06
`define CAS_RD_UNMAPPED    8'h00
`define CAS_MODE_RESET     4'hF
`define CAS_FLAGS_RESET    4'h0
`define CAS_PROC_PAD       2'h0
`define CAS_SP_RESET       4'h0
`define CAS_SP_FULL        4'hF
`define CAS_GLINT_RESET    1'b1
`define CAS_STACK_RESET    1'b1
`define CAS_EXPIRY_RESET   1'b1
`define CAS_SLEEP_RESET    1'b1
`define CAS_PWRUP_RESET    1'b0
`define CAS_DIP_RESET      1'b1
`define CAS_PROC_MASK_BIT  4
`define CAS_PROC_PWRUP_BIT 1
`define CAS_PROC_DIP_BIT   0

`endif

// ==== design/cas_pkg.sv ====
/*
 types of the status register bank: alu operations, flag set, request.
 assumes the constants header supplies every number.
*/
package cas_pkg;

   typedef enum logic [3:0] {
      op_none, op_add, op_sub, op_and, op_or, op_xor,
      op_clr, op_mov, op_rlc, op_rrc
   } cas_alu_op_e;

   typedef enum logic [1:0] {
      cause_ext_pin, cause_watchdog, cause_brownout
   } cas_reset_cause_e;

   typedef enum logic [1:0] {
      step_dec, step_inc, step_hold
   } cas_step_e;

   // bit order matches register bits 3..0
   typedef struct packed {
      logic ov;
      logic z;
      logic dc;
      logic c;
   } cas_flags_s;

   typedef struct packed {
      cas_alu_op_e op;
      logic        use_literal;
      logic        single_on_w;
      logic [7:0]  literal;
      logic [7:0]  file_operand;
      logic [7:0]  w_operand;
      logic        wr_en;
      logic [7:0]  wr_addr;
   } cas_alu_req_s;

endpackage : cas_pkg

// ==== design/cas_alu.sv ====
/*
 arithmetic unit: result, new flags and which flags the op affects.
 assumes a purely combinational use by the status register bank.
*/
`timescale 1ns/1ns
module cas_alu (
   // request
   input  wire cas_pkg::cas_alu_req_s req,
   input  wire logic                  carry_in,
   // answer
   output logic [7:0]                 result,
   output cas_pkg::cas_flags_s        flags,
   output cas_pkg::cas_flags_s        affect
);

   logic [7:0] single;
   logic [7:0] second;
   logic [7:0] inv_w;
   logic [8:0] sum9;
   logic [4:0] nib5;

   always_comb begin
      single = req.single_on_w ? req.w_operand : req.file_operand;
      second = req.use_literal ? req.literal : req.file_operand;
      inv_w  = ~req.w_operand;
      sum9   = 9'h000;
      nib5   = 5'h00;
      result = 8'h00;
      flags  = '0;
      affect = '0;
      case (req.op)
         cas_pkg::op_add: begin
            sum9      = {1'b0, req.w_operand} + {1'b0, second};
            nib5      = {1'b0, req.w_operand[3:0]} + {1'b0, second[3:0]};
            result    = sum9[7:0];
            flags.c   = sum9[8];
            flags.dc  = nib5[4];
            flags.ov  = (req.w_operand[7] == second[7]) && (result[7] != second[7]);
            affect    = '1;
         end
         cas_pkg::op_sub: begin
            sum9      = {1'b0, second} + {1'b0, inv_w} + 9'h001;
            nib5      = {1'b0, second[3:0]} + {1'b0, inv_w[3:0]} + 5'h01;
            result    = sum9[7:0];
            flags.c   = sum9[8];
            flags.dc  = nib5[4];
            flags.ov  = (second[7] == inv_w[7]) && (result[7] != second[7]);
            affect    = '1;
         end
         cas_pkg::op_and: begin
            result   = req.w_operand & second;
            affect.z = 1'b1;
         end
         cas_pkg::op_or: begin
            result   = req.w_operand | second;
            affect.z = 1'b1;
         end
         cas_pkg::op_xor: begin
            result   = req.w_operand ^ second;
            affect.z = 1'b1;
         end
         cas_pkg::op_clr: begin
            result   = 8'h00;
            affect.z = 1'b1;
         end
         cas_pkg::op_mov: begin
            result = single;
         end
         cas_pkg::op_rlc: begin
            result   = {single[6:0], carry_in};
            flags.c  = single[7];
            affect.c = 1'b1;
         end
         cas_pkg::op_rrc: begin
            result   = {carry_in, single[7:1]};
            flags.c  = single[0];
            affect.c = 1'b1;
         end
         default: begin
            result = 8'h00;
         end
      endcase
      flags.z = (result == 8'h00);
   end

endmodule : cas_alu

// ==== design/cas_status_regs.sv ====
/*
 arithmetic status and processor status registers of the core.
 assumes one clock, datapath pulses of one cycle, one access per cycle.
*/
`timescale 1ns/1ns
`include "cas_cfg.svh"
module cas_status_regs #(
   parameter int IRQ_SOURCES = 4
) (
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   input  wire logic                          clk_en,
   // data memory access
   input  wire logic                          sw_wr_en,
   input  wire logic [7:0]                    sw_wr_addr,
   input  wire logic [7:0]                    sw_wr_data,
   input  wire logic                          rd_en,
   input  wire logic [7:0]                    rd_addr,
   output logic [7:0]                         rd_data,
   output logic                               rd_hit,
   // alu instruction
   input  wire logic                          alu_go,
   input  wire cas_pkg::cas_alu_req_s         alu_req,
   output logic [7:0]                         alu_result,
   output logic                               alu_result_valid,
   // core events
   input  wire logic                          push_pulse,
   input  wire logic                          pop_pulse,
   input  wire logic                          clrwdt_pulse,
   input  wire logic                          sleep_pulse,
   input  wire logic                          wdt_timeout_pulse,
   input  wire logic                          dev_reset_pulse,
   input  wire cas_pkg::cas_reset_cause_e     reset_cause,
   input  wire logic                          brownout_detect_enable,
   // interrupts
   input  wire logic [IRQ_SOURCES-1:0]        irq_flags,
   input  wire logic [IRQ_SOURCES-1:0]        irq_enables,
   output logic                               irq_request,
   // pointer stepping
   output cas_pkg::cas_step_e [1:0]           ptr_step
);

   logic                rst_meta_n;
   logic                rst_sync_n;
   logic [3:0]          mode;
   logic [3:0]          next_mode;
   cas_pkg::cas_flags_s flags;
   cas_pkg::cas_flags_s next_flags;
   logic [3:0]          sp;
   logic [3:0]          next_sp;
   logic                lock;
   logic                next_lock;
   logic                stack_space_flag;
   logic                next_stack_space_flag;
   logic                global_interrupt_mask;
   logic                next_global_interrupt_mask;
   logic                to_flag;
   logic                next_to_flag;
   logic                pd_flag;
   logic                next_pd_flag;
   logic                por_flag;
   logic                next_por_flag;
   logic                bor_flag;
   logic                next_bor_flag;
   logic [7:0]          next_rd_data;
   logic                next_rd_hit;
   logic                next_irq_request;
   logic [7:0]          next_alu_result;
   logic                next_alu_result_valid;
   logic [7:0]          alu_out;
   cas_pkg::cas_flags_s alu_flags;
   cas_pkg::cas_flags_s alu_aff;
   logic                sw_arith;
   logic                sw_proc;
   logic                alu_arith;
   logic                alu_proc;

   // reset release
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   cas_alu u_alu (
      .req      (alu_req),
      .carry_in (flags.c),
      .result   (alu_out),
      .flags    (alu_flags),
      .affect   (alu_aff)
   );

   assign sw_arith  = sw_wr_en && (sw_wr_addr == `CAS_ADDR_ARITH);
   assign sw_proc   = sw_wr_en && (sw_wr_addr == `CAS_ADDR_PROC);
   assign alu_arith = alu_go && alu_req.wr_en && (alu_req.wr_addr == `CAS_ADDR_ARITH);
   assign alu_proc  = alu_go && alu_req.wr_en && (alu_req.wr_addr == `CAS_ADDR_PROC);

   // step decode per pointer
   generate
      for (genvar i = 0; i < 2; i++) begin : g_step
         assign ptr_step[i] = mode[2*i+1] ? cas_pkg::step_hold :
                              (mode[2*i] ? cas_pkg::step_inc : cas_pkg::step_dec);
      end
   endgenerate

   // arithmetic status next state
   always_comb begin
      next_mode  = mode;
      next_flags = flags;
      if (sw_arith) begin
         {next_mode, next_flags} = sw_wr_data;
      end
      if (alu_go) begin
         if (alu_arith) begin
            next_mode  = alu_out[7:4];
            next_flags = cas_pkg::cas_flags_s'(alu_out[3:0]);
         end
         if (alu_aff.ov) next_flags.ov = alu_flags.ov;
         if (alu_aff.z) next_flags.z = alu_flags.z;
         if (alu_aff.dc) next_flags.dc = alu_flags.dc;
         if (alu_aff.c) next_flags.c = alu_flags.c;
      end
      if (dev_reset_pulse) begin
         next_mode = `CAS_MODE_RESET;
      end
   end

   // processor status next state
   always_comb begin
      next_sp       = sp;
      next_lock     = lock;
      next_global_interrupt_mask   = global_interrupt_mask;
      next_to_flag  = to_flag;
      next_pd_flag  = pd_flag;
      next_por_flag = por_flag;
      next_bor_flag = bor_flag;
      if (push_pulse && !pop_pulse) begin
         if (sp == `CAS_SP_FULL) next_lock = 1'b1;
         next_sp = 4'(sp + 4'h1);
      end else if (pop_pulse && !push_pulse) begin
         next_sp = 4'(sp - 4'h1);
      end
      if (sw_proc) begin
         next_global_interrupt_mask   = sw_wr_data[`CAS_PROC_MASK_BIT];
         next_por_flag = sw_wr_data[`CAS_PROC_PWRUP_BIT];
         next_bor_flag = sw_wr_data[`CAS_PROC_DIP_BIT];
      end
      if (alu_proc) begin
         next_global_interrupt_mask   = alu_out[`CAS_PROC_MASK_BIT];
         next_por_flag = alu_out[`CAS_PROC_PWRUP_BIT];
         next_bor_flag = alu_out[`CAS_PROC_DIP_BIT];
      end
      if (clrwdt_pulse) begin
         next_to_flag = 1'b1;
         next_pd_flag = 1'b1;
      end
      if (sleep_pulse) begin
         next_to_flag = 1'b1;
         next_pd_flag = 1'b0;
      end
      if (wdt_timeout_pulse) begin
         next_to_flag = 1'b0;
      end
      if (dev_reset_pulse) begin
         next_sp     = `CAS_SP_RESET;
         next_lock   = 1'b0;
         next_global_interrupt_mask = `CAS_GLINT_RESET;
         if (reset_cause == cas_pkg::cause_watchdog) begin
            next_to_flag = 1'b0;
         end
         if (reset_cause == cas_pkg::cause_brownout && brownout_detect_enable) begin
            next_bor_flag = 1'b0;
         end
      end
      next_stack_space_flag = !next_lock && (next_sp != `CAS_SP_FULL);
   end

   // read port, interrupt gate, alu result
   always_comb begin
      next_rd_data          = `CAS_RD_UNMAPPED;
      next_rd_hit           = 1'b0;
      if (rd_en && rd_addr == `CAS_ADDR_ARITH) begin
         next_rd_data = {mode, flags};
         next_rd_hit  = 1'b1;
      end else if (rd_en && rd_addr == `CAS_ADDR_PROC) begin
         next_rd_data = {`CAS_PROC_PAD, stack_space_flag, global_interrupt_mask, to_flag, pd_flag,
                         por_flag, bor_flag};
         next_rd_hit  = 1'b1;
      end
      next_irq_request      = !global_interrupt_mask && |(irq_flags & irq_enables);
      next_alu_result       = alu_go ? alu_out : alu_result;
      next_alu_result_valid = alu_go;
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode             <= `CAS_MODE_RESET;
         flags            <= `CAS_FLAGS_RESET;
         sp               <= `CAS_SP_RESET;
         lock             <= 1'b0;
         stack_space_flag            <= `CAS_STACK_RESET;
         global_interrupt_mask           <= `CAS_GLINT_RESET;
         to_flag          <= `CAS_EXPIRY_RESET;
         pd_flag          <= `CAS_SLEEP_RESET;
         por_flag         <= `CAS_PWRUP_RESET;
         bor_flag         <= `CAS_DIP_RESET;
         rd_data          <= `CAS_RD_UNMAPPED;
         rd_hit           <= 1'b0;
         irq_request      <= 1'b0;
         alu_result       <= 8'h00;
         alu_result_valid <= 1'b0;
      end else if (clk_en) begin
         mode             <= next_mode;
         flags            <= next_flags;
         sp               <= next_sp;
         lock             <= next_lock;
         stack_space_flag            <= next_stack_space_flag;
         global_interrupt_mask           <= next_global_interrupt_mask;
         to_flag          <= next_to_flag;
         pd_flag          <= next_pd_flag;
         por_flag         <= next_por_flag;
         bor_flag         <= next_bor_flag;
         rd_data          <= next_rd_data;
         rd_hit           <= next_rd_hit;
         irq_request      <= next_irq_request;
         alu_result       <= next_alu_result;
         alu_result_valid <= next_alu_result_valid;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_n);

   property p_flag_write_ignored;
      clk_en && alu_arith && alu_aff.z && !dev_reset_pulse |=> flags.z == $past(alu_flags.z);
   endproperty
   a_flag_write_ignored: assert property (p_flag_write_ignored)
      else $error("flag write not ignored");

   property p_sub_no_borrow;
      clk_en && alu_go && alu_req.op == cas_pkg::op_sub && !alu_req.use_literal
         && alu_req.file_operand >= alu_req.w_operand && !sw_arith |=> flags.c;
   endproperty
   a_sub_no_borrow: assert property (p_sub_no_borrow)
      else $error("carry low without borrow");

   property p_signed_range;
      clk_en && alu_go && alu_req.op == cas_pkg::op_add && alu_req.use_literal
         && alu_req.w_operand == 8'h7F && alu_req.literal == 8'h01 |=> flags.ov;
   endproperty
   a_signed_range: assert property (p_signed_range)
      else $error("signed range flag not set");

   property p_zero_flag;
      clk_en && alu_go && alu_aff.z && !alu_arith |=> flags.z == (alu_result == 8'h00);
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag disagrees with result");

   property p_rotate_carry;
      clk_en && alu_go && alu_req.op == cas_pkg::op_rlc && !alu_req.single_on_w
         && !alu_arith |=> flags.c == $past(alu_req.file_operand[7]);
   endproperty
   a_rotate_carry: assert property (p_rotate_carry)
      else $error("rotate carry wrong");

   property p_top_bits_zero;
      clk_en && rd_en && rd_addr == `CAS_ADDR_PROC |=> rd_hit && rd_data[7:6] == 2'h0;
   endproperty
   a_top_bits_zero: assert property (p_top_bits_zero)
      else $error("processor status top bits not zero");

   property p_stack_lock;
      clk_en && push_pulse && !pop_pulse && sp == `CAS_SP_FULL && !dev_reset_pulse
         |=> !stack_space_flag ##1 (!stack_space_flag || $past(dev_reset_pulse && clk_en));
   endproperty
   a_stack_lock: assert property (p_stack_lock)
      else $error("stack flag not held clear");

   property p_mask_blocks;
      clk_en && global_interrupt_mask |=> !irq_request;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("interrupt passed the mask");

   property p_timeout_clears;
      clk_en && wdt_timeout_pulse |=> !to_flag;
   endproperty
   a_timeout_clears: assert property (p_timeout_clears)
      else $error("expiry flag not cleared");

   property p_pin_reset_keeps;
      clk_en && dev_reset_pulse && reset_cause == cas_pkg::cause_ext_pin && !clrwdt_pulse
         && !sleep_pulse && !wdt_timeout_pulse
         |=> to_flag == $past(to_flag) && pd_flag == $past(pd_flag) && sp == 4'h0 && stack_space_flag;
   endproperty
   a_pin_reset_keeps: assert property (p_pin_reset_keeps)
      else $error("pin reset disturbed status");

   property p_flags_quiet;
      clk_en && !alu_go && !sw_arith |=> $stable(flags);
   endproperty
   a_flags_quiet: assert property (p_flags_quiet)
      else $error("flags moved without an instruction");

   cover property (clk_en && alu_go && alu_req.op == cas_pkg::op_sub ##1 !flags.c);
   cover property (clk_en && push_pulse && sp == `CAS_SP_FULL);
   cover property (clk_en && sleep_pulse ##[1:20] clk_en && clrwdt_pulse);
   cover property (clk_en && alu_arith && alu_req.op == cas_pkg::op_clr);

endmodule : cas_status_regs

// ==== verification/cas_core_model.sv ====
/*
 core model: instruction and event pulses seen by the status register bank.
 assumes the bench calls fire() from its own sequence, one event at a time.
*/
`timescale 1ns/1ns
module cas_core_model (
   // clock
   input  wire logic                      ref_clk,
   // event pulses
   output logic                           push_pulse,
   output logic                           pop_pulse,
   output logic                           clrwdt_pulse,
   output logic                           sleep_pulse,
   output logic                           wdt_timeout_pulse,
   output logic                           dev_reset_pulse,
   output cas_pkg::cas_reset_cause_e      reset_cause
);
   logic [5:0] ev = 6'h00;

   initial reset_cause = cas_pkg::cause_ext_pin;

   assign push_pulse        = ev[0];
   assign pop_pulse         = ev[1];
   assign clrwdt_pulse      = ev[2];
   assign sleep_pulse       = ev[3];
   assign wdt_timeout_pulse = ev[4];
   assign dev_reset_pulse   = ev[5];

   // one-cycle pulse, launched off the falling edge
   task automatic fire(input logic [5:0] kind, input cas_pkg::cas_reset_cause_e cause);
      @(negedge ref_clk);
      ev = kind;
      reset_cause = cause;
      @(negedge ref_clk);
      ev = 6'h00;
      reset_cause = cas_pkg::cause_ext_pin;
   endtask : fire
endmodule : cas_core_model

// ==== verification/cas_status_regs_bench.sv ====
/*
 self-checking bench of the status register bank: register reads and writes,
 alu operations and core events. assumes default parameters and the core model.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin \
   num_checks++; \
   if ((a) !== (b)) begin \
      errors++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); \
   end \
end
module cas_status_regs_bench;
   logic                       ref_clk;
   logic                       rstn                   = 1'b0;
   logic                       clk_en                 = 1'b1;
   logic                       sw_wr_en               = 1'b0;
   logic [7:0]                 sw_wr_addr             = 8'h00;
   logic [7:0]                 sw_wr_data             = 8'h00;
   logic                       rd_en                  = 1'b0;
   logic [7:0]                 rd_addr                = 8'h00;
   logic                       alu_go                 = 1'b0;
   cas_pkg::cas_alu_req_s      alu_req                = '0;
   logic                       brownout_detect_enable = 1'b1;
   logic [3:0]                 irq_flags              = 4'h0;
   logic [3:0]                 irq_enables            = 4'h0;
   logic [7:0]                 rd_data;
   logic                       rd_hit;
   logic [7:0]                 alu_result;
   logic                       alu_result_valid;
   logic                       irq_request;
   logic                       push_pulse;
   logic                       pop_pulse;
   logic                       clrwdt_pulse;
   logic                       sleep_pulse;
   logic                       wdt_timeout_pulse;
   logic                       dev_reset_pulse;
   cas_pkg::cas_reset_cause_e  reset_cause;
   cas_pkg::cas_step_e [1:0]   ptr_step;
   int                         errors                 = 0;
   int                         num_checks             = 0;

   cas_status_regs #(.IRQ_SOURCES(4)) u_cas_status_regs (
      .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
      .sw_wr_en(sw_wr_en), .sw_wr_addr(sw_wr_addr), .sw_wr_data(sw_wr_data),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit),
      .alu_go(alu_go), .alu_req(alu_req), .alu_result(alu_result),
      .alu_result_valid(alu_result_valid),
      .push_pulse(push_pulse), .pop_pulse(pop_pulse), .clrwdt_pulse(clrwdt_pulse),
      .sleep_pulse(sleep_pulse), .wdt_timeout_pulse(wdt_timeout_pulse),
      .dev_reset_pulse(dev_reset_pulse), .reset_cause(reset_cause),
      .brownout_detect_enable(brownout_detect_enable),
      .irq_flags(irq_flags), .irq_enables(irq_enables), .irq_request(irq_request),
      .ptr_step(ptr_step)
   );

   cas_core_model u_cas_core_model (
      .ref_clk(ref_clk), .push_pulse(push_pulse), .pop_pulse(pop_pulse),
      .clrwdt_pulse(clrwdt_pulse), .sleep_pulse(sleep_pulse),
      .wdt_timeout_pulse(wdt_timeout_pulse), .dev_reset_pulse(dev_reset_pulse),
      .reset_cause(reset_cause)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sw_wr_en = 1'b1;
      sw_wr_addr = a;
      sw_wr_data = d;
      @(negedge ref_clk);
      sw_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      @(negedge ref_clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      `CHK(rd_data, exp)
      `CHK(rd_hit, hit)
   endtask : rd

   task automatic mode(input logic [7:0] d, input cas_pkg::cas_step_e s1, s0);
      wr(8'h04, d);
      `CHK(ptr_step[1], s1)
      `CHK(ptr_step[0], s0)
   endtask : mode

   task automatic ev(input logic [5:0] k, input cas_pkg::cas_reset_cause_e c);
      u_cas_core_model.fire(k, c);
   endtask : ev

   // sel = {result to 04h, single on w, literal}
   task automatic alu(input cas_pkg::cas_alu_op_e op, input logic [2:0] sel,
                      input logic [7:0] lit, f, w, res, stat);
      @(negedge ref_clk);
      alu_go = 1'b1;
      alu_req.op = op;
      alu_req.use_literal = sel[0];
      alu_req.single_on_w = sel[1];
      alu_req.wr_en = sel[2];
      alu_req.wr_addr = 8'h04;
      alu_req.literal = lit;
      alu_req.file_operand = f;
      alu_req.w_operand = w;
      @(negedge ref_clk);
      alu_go = 1'b0;
      `CHK(alu_result_valid, 1'b1)
      `CHK(alu_result, res)
      rd(8'h04, stat, 1'b1);
   endtask : alu

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      end_sim();
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (3) @(posedge ref_clk);
      // reset values and decode
      rd(8'h04, 8'hF0, 1'b1);
      rd(8'h06, 8'h3D, 1'b1);
      rd(8'h05, 8'h00, 1'b0);
      mode(8'h00, cas_pkg::step_dec, cas_pkg::step_dec);
      mode(8'h50, cas_pkg::step_inc, cas_pkg::step_inc);
      mode(8'hA0, cas_pkg::step_hold, cas_pkg::step_hold);
      mode(8'h9F, cas_pkg::step_hold, cas_pkg::step_inc);
      wr(8'h04, 8'h30);
      clk_en = 1'b0;
      wr(8'h04, 8'hFF);
      clk_en = 1'b1;
      rd(8'h04, 8'h30, 1'b1);
      // processor status writes
      wr(8'h06, 8'hFF);
      rd(8'h06, 8'h3F, 1'b1);
      wr(8'h06, 8'h00);
      rd(8'h06, 8'h2C, 1'b1);
      wr(8'h06, 8'h03);
      rd(8'h06, 8'h2F, 1'b1);
      // interrupt gating
      irq_flags = 4'h1;
      irq_enables = 4'h1;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_request, 1'b1)
      irq_enables = 4'h2;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_request, 1'b0)
      irq_enables = 4'h1;
      wr(8'h06, 8'h13);
      repeat (2) @(negedge ref_clk);
      `CHK(irq_request, 1'b0)
      irq_flags = 4'h0;
      rd(8'h06, 8'h3F, 1'b1);
      // stack flag
      repeat (15) ev(6'h01, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h1F, 1'b1);
      ev(6'h02, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h3F, 1'b1);
      ev(6'h01, cas_pkg::cause_ext_pin);
      ev(6'h01, cas_pkg::cause_ext_pin);
      ev(6'h02, cas_pkg::cause_ext_pin);
      ev(6'h01, cas_pkg::cause_ext_pin);
      ev(6'h01, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h1F, 1'b1);
      wr(8'h06, 8'h3F);
      rd(8'h06, 8'h1F, 1'b1);
      // watchdog, sleep and device resets
      ev(6'h08, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h1B, 1'b1);
      ev(6'h10, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h13, 1'b1);
      ev(6'h20, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h33, 1'b1);
      rd(8'h04, 8'hF0, 1'b1);
      repeat (15) ev(6'h01, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h13, 1'b1);
      ev(6'h04, cas_pkg::cause_ext_pin);
      rd(8'h06, 8'h1F, 1'b1);
      ev(6'h20, cas_pkg::cause_watchdog);
      rd(8'h06, 8'h37, 1'b1);
      ev(6'h04, cas_pkg::cause_ext_pin);
      wr(8'h06, 8'h03);
      rd(8'h06, 8'h2F, 1'b1);
      ev(6'h20, cas_pkg::cause_brownout);
      rd(8'h06, 8'h3E, 1'b1);
      wr(8'h06, 8'h03);
      rd(8'h06, 8'h2F, 1'b1);
      // detection off: supply dip flag kept
      brownout_detect_enable = 1'b0;
      ev(6'h20, cas_pkg::cause_brownout);
      rd(8'h06, 8'h3F, 1'b1);
      brownout_detect_enable = 1'b1;
      // alu flags
      wr(8'h04, 8'hF0);
      alu(cas_pkg::op_add, 3'b000, 8'h00, 8'h7F, 8'h01, 8'h80, 8'hFA);
      alu(cas_pkg::op_add, 3'b001, 8'h01, 8'h00, 8'h7F, 8'h80, 8'hFA);
      alu(cas_pkg::op_sub, 3'b000, 8'h00, 8'h05, 8'h03, 8'h02, 8'hF3);
      alu(cas_pkg::op_sub, 3'b000, 8'h00, 8'h03, 8'h05, 8'hFE, 8'hF0);
      alu(cas_pkg::op_sub, 3'b000, 8'h00, 8'h80, 8'h01, 8'h7F, 8'hF9);
      alu(cas_pkg::op_add, 3'b000, 8'h00, 8'hFF, 8'h01, 8'h00, 8'hF7);
      alu(cas_pkg::op_add, 3'b001, 8'h10, 8'h99, 8'h20, 8'h30, 8'hF0);
      alu(cas_pkg::op_and, 3'b000, 8'h00, 8'hF0, 8'h0F, 8'h00, 8'hF4);
      alu(cas_pkg::op_rlc, 3'b000, 8'h00, 8'h80, 8'h00, 8'h00, 8'hF5);
      alu(cas_pkg::op_rrc, 3'b010, 8'h00, 8'h55, 8'h02, 8'h81, 8'hF4);
      alu(cas_pkg::op_or, 3'b000, 8'h00, 8'h12, 8'h40, 8'h52, 8'hF0);
      alu(cas_pkg::op_clr, 3'b000, 8'h00, 8'h12, 8'h40, 8'h00, 8'hF4);
      alu(cas_pkg::op_xor, 3'b000, 8'h00, 8'hAA, 8'h55, 8'hFF, 8'hF0);
      alu(cas_pkg::op_mov, 3'b010, 8'h00, 8'h3C, 8'h00, 8'h00, 8'hF0);
      alu(cas_pkg::op_sub, 3'b001, 8'h10, 8'h99, 8'h01, 8'h0F, 8'hF1);
      // alu result written to the arithmetic status register
      wr(8'h04, 8'hF0);
      alu(cas_pkg::op_clr, 3'b100, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04);
      alu(cas_pkg::op_add, 3'b100, 8'h00, 8'h7F, 8'h01, 8'h80, 8'h8A);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'hFF, 1'b1);
      end_sim();
   end
endmodule : cas_status_regs_bench
